/* include/flash_host_map.svh */
// constants and timing for the parallel flash host controller
// Functional notes
// R1 - width select high gives sixteen-bit words
// R2 - width select low: byte mode, pin15 addresses
// R3 - reads: chip select, output enable low, write high
// R4 - after reset device reads array
// R5 - array data until command register changes
// R6 - writes: write, chip select low, output enable high
// R7 - unlock bypass programs in two writes
// R8 - erase sector, several sectors, or whole chip
// R9 - identification codes read on low byte
// R10 - status bits read during embedded operations
// R11 - standby floats outputs regardless output enable
// R12 - wait chip-select access time after standby
// R13 - embedded operation continues when deselected
// R14 - stable address enters automatic sleep
// R15 - output enable high floats data pins
// R16 - reset aborts, floats, then array read
// R17 - host restarts interrupted program or erase
// R18 - ready/busy low until reset completes
// R19 - top boot sector decode from bits 17:12
// R20 - bottom boot sector decode layout
// R21 - address on later fall, data earlier rise
// R22 - bad sequence returns device to array read
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
// ==========================================================
// timing, in ns and derived cycles at 25 MHz
`define CLK_PERIOD_NS 40
`define ACCESS_TIME_NS 70
`define WRITE_PULSE_NS 35
`define SETUP_TIME_NS 40
`define RESET_PULSE_NS 500
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define ACCESS_CYC `CYC_UP(`ACCESS_TIME_NS)
`define WRITE_CYC `CYC_UP(`WRITE_PULSE_NS)
`define SETUP_CYC `CYC_UP(`SETUP_TIME_NS)
`define RESET_CYC `CYC_UP(`RESET_PULSE_NS)
// ==========================================================
// sector boundaries, byte addresses
`define TOP_SMALL32_BASE 20'h7_0000
`define TOP_SMALL8_BASE 20'h7_8000
`define TOP_SMALL16_BASE 20'h7_C000
`define BOT_SMALL8A_BASE 20'h0_4000
`define BOT_SMALL8B_BASE 20'h0_6000
`define BOT_SMALL32_BASE 20'h0_8000
`endif

/* include/flash_host_pkg.sv */
// types shared by the flash host controller
package flash_host_pkg;
  typedef enum {
    ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_RESET
  } host_state_type;
  typedef logic [3:0] sector_type;
endpackage

/* hdl/sector_decode.sv */
// sector number from a byte address, top or bottom boot layout
`timescale 1ns/1ps
`include "flash_host_map.svh"
module sector_decode import flash_host_pkg::*; (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, active low
  input wire logic top_boot, // 1 top-boot layout
  input wire logic [19:0] byte_addr, // byte address
  output sector_type sector_q // registered sector index
);
  function automatic sector_type decode(input logic top, input logic [19:0] a);
    sector_type s;
    s = 4'h0;
    if (top) begin
      if (a < `TOP_SMALL32_BASE) s = sector_type'(a[18:16]); // R19
      else if (a < `TOP_SMALL8_BASE) s = 4'h7;
      else if (a < `TOP_SMALL16_BASE) s = a[13] ? 4'h9 : 4'h8;
      else s = 4'hA;
    end else begin
      if (a < `BOT_SMALL8A_BASE) s = 4'h0; // R20
      else if (a < `BOT_SMALL8B_BASE) s = 4'h1;
      else if (a < `BOT_SMALL32_BASE) s = 4'h2;
      else if (a[19:16] == 4'h0) s = 4'h3;
      else s = sector_type'({1'b0, a[18:16]} + 4'h3);
    end
    return s;
  endfunction
  always_ff @(posedge clk) begin
    if (!rstn) sector_q <= 4'h0;
    else sector_q <= decode(top_boot, byte_addr); // R8
  end
endmodule

/* hdl/flash_host.sv */
// host controller driving the parallel flash pins
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host import flash_host_pkg::*; #(
  parameter int RESET_CYCLES = `RESET_CYC
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire logic word_mode, // 1 sixteen-bit bus
  input wire logic top_boot, // boot layout of fitted part
  input wire logic req_valid, // request pulse
  input wire logic req_write, // 1 write cycle, 0 read
  input wire logic [18:0] req_addr, // word or byte-high address
  input wire logic req_lsb, // byte address bit in byte mode
  input wire logic [15:0] req_wdata, // write data
  input wire logic reset_req, // pulse: hardware reset the flash
  input wire logic standby_req, // level: deselect flash
  output logic busy_q, // controller busy
  output logic rvalid_q, // read data valid pulse
  output logic [15:0] rdata_q, // read data
  output logic [3:0] sector_q, // sector of current req_addr, registered every cycle
  output logic dev_busy_q, // sampled ready/busy low
  output logic [17:0] addr_q, // flash address pins
  output logic ce_n_q, // chip select, active low
  output logic oe_n_q, // output enable, active low
  output logic we_n_q, // write strobe, active low
  output logic rst_n_q, // flash reset, active low
  output logic byte_n_q, // width select
  output logic [15:0] dq_out_q, // data out
  output logic [15:0] dq_oe_q, // data output enable
  input wire logic [15:0] dq_in, // data in
  input wire logic ready_busy_out // device ready/busy
);
  host_state_type state_q;
  logic [9:0] cnt_q;
  logic [19:0] byte_addr;
  logic was_standby_q;
  // ==========================================================
  // last wait cycle of a read, where data is taken
  function automatic logic read_last(input host_state_type st, input logic [9:0] c);
    return st == ST_RD_WAIT && c == 10'(`ACCESS_CYC);
  endfunction
  // ==========================================================
  // sector tracking, for erase bookkeeping
  assign byte_addr = word_mode ? {req_addr[17:0], 1'b0, 1'b0} >> 1 : {req_addr, req_lsb};
  sector_decode u_dec (
    .clk(clk),
    .rstn(rstn),
    .top_boot(top_boot),
    .byte_addr(byte_addr),
    .sector_q(sector_q)
  );
  // ==========================================================
  // bus cycle sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 10'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 10'h000;
          if (reset_req) state_q <= ST_RESET; // R16
          else if (req_valid && !standby_req) state_q <= req_write ? ST_WR_SETUP : ST_RD_SETUP;
        end
        ST_RD_SETUP: begin
          // after standby the full chip-select access time is allowed anyway
          state_q <= ST_RD_WAIT; // R12
        end
        ST_RD_WAIT: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q == 10'(`ACCESS_CYC)) state_q <= ST_IDLE;
        end
        ST_WR_SETUP: begin
          cnt_q <= 10'h000;
          state_q <= ST_WR_PULSE;
        end
        ST_WR_PULSE: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q == 10'(`WRITE_CYC - 1)) state_q <= ST_WR_HOLD;
        end
        ST_WR_HOLD: state_q <= ST_IDLE;
        ST_RESET: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q == 10'(RESET_CYCLES - 1)) state_q <= ST_IDLE; // R4
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // flash pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rst_n_q <= 1'b1;
      byte_n_q <= 1'b1;
      addr_q <= 18'h0_0000;
      dq_out_q <= 16'h0000;
      dq_oe_q <= 16'h0000;
    end else begin
      byte_n_q <= word_mode; // R1 R2
      // low for all RESET_CYCLES cycles, so the pulse meets the minimum width
      rst_n_q <= !(state_q == ST_RESET); // R16
      if (state_q == ST_IDLE && req_valid && !reset_req && !standby_req) begin
        addr_q <= req_addr[17:0]; // R14
        dq_out_q <= word_mode ? req_wdata : {req_lsb, 7'h00, req_wdata[7:0]}; // R2
        // pin 15 carries the byte address in byte mode, driven from the first byte-mode request on
        dq_oe_q <= word_mode ? (req_write ? 16'hFFFF : 16'h0000)
                             : {1'b1, 7'h00, {8{req_write}}}; // R2
      end else if (state_q == ST_IDLE) begin
        dq_oe_q <= word_mode ? 16'h0000 : {dq_oe_q[15], 15'h0000};
      end
      case (state_q)
        ST_RD_SETUP: begin
          ce_n_q <= 1'b0; // R3
          oe_n_q <= 1'b0;
          we_n_q <= 1'b1;
        end
        ST_WR_SETUP: begin
          ce_n_q <= 1'b0; // R6
          oe_n_q <= 1'b1;
        end
        ST_WR_PULSE: begin
          // address latched on this falling strobe, data on its rise
          we_n_q <= 1'b0; // R21
        end
        ST_WR_HOLD: begin
          // chip select lifts a cycle later, so the write strobe rises first
          we_n_q <= 1'b1; // R21
        end
        ST_RD_WAIT: begin
          if (cnt_q == 10'(`ACCESS_CYC)) begin
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
          end
        end
        default: begin
          ce_n_q <= 1'b1;
          oe_n_q <= 1'b1;
          we_n_q <= 1'b1;
        end
      endcase
    end
  end
  // ==========================================================
  // read data capture and status
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 16'h0000;
      busy_q <= 1'b0;
      dev_busy_q <= 1'b0;
      was_standby_q <= 1'b0;
    end else begin
      was_standby_q <= standby_req;
      dev_busy_q <= !ready_busy_out; // R10 R13 R18
      busy_q <= state_q != ST_IDLE || (req_valid && !standby_req) || reset_req;
      rvalid_q <= read_last(state_q, cnt_q);
      if (read_last(state_q, cnt_q))
        rdata_q <= word_mode ? dq_in : {8'h00, dq_in[7:0]}; // R5 R9 R10
    end
  end
  // ==========================================================
  // checks
  read_strobes_a: assert property (@(posedge clk) disable iff (!rstn)
    (!oe_n_q && !ce_n_q) |-> we_n_q) else $error("write strobe low during read"); // R3
  write_strobes_a: assert property (@(posedge clk) disable iff (!rstn)
    !we_n_q |-> (!ce_n_q && oe_n_q)) else $error("bad write strobes"); // R6
  width_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 byte_n_q == $past(word_mode)) else $error("width select lag"); // R1
  byte_float_a: assert property (@(posedge clk) disable iff (!rstn)
    !byte_n_q |-> dq_oe_q[14:8] == 7'h00) else $error("upper pins driven"); // R2
  reset_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(rst_n_q) |-> !rst_n_q [*2]) else $error("reset pulse short"); // R16
  rd_valid_a: assert property (@(posedge clk) disable iff (!rstn)
    rvalid_q |-> $past(!oe_n_q && !ce_n_q)) else $error("read without strobes"); // R12
  no_contend_a: assert property (@(posedge clk) disable iff (!rstn)
    (!oe_n_q && !ce_n_q) |-> dq_oe_q[7:0] == 8'h00) else $error("bus contention"); // R15
  standby_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    (was_standby_q && standby_req && state_q == ST_IDLE) |=> ce_n_q)
    else $error("selected in standby"); // R11
  busy_track_a: assert property (@(posedge clk) disable iff (!rstn)
    !ready_busy_out |=> dev_busy_q) else $error("busy not seen"); // R18
  rd_cover: cover property (@(posedge clk) rvalid_q);
  wr_cover: cover property (@(posedge clk) $rose(we_n_q));
  rst_cover: cover property (@(posedge clk) $rose(rst_n_q));
  byte_rd_cover: cover property (@(posedge clk) rvalid_q && !byte_n_q);
  busy_rst_cover: cover property (@(posedge clk) $fell(rst_n_q) && dev_busy_q);
  reset_deselect_a: assert property (@(posedge clk) disable iff (!rstn) // R16
    !rst_n_q |-> (ce_n_q && oe_n_q && we_n_q))
    else $error("strobes active during flash reset");
  reset_float_a: assert property (@(posedge clk) disable iff (!rstn) // R16
    !rst_n_q |-> dq_oe_q[14:0] == 15'h0000)
    else $error("data pins driven during flash reset");
  write_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R21
    !we_n_q |-> ($stable(addr_q) && $stable(dq_out_q)))
    else $error("address or data moved under write strobe");
  read_addr_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R14
    (!oe_n_q && !ce_n_q) |-> $stable(addr_q))
    else $error("address moved during read");
  rvalid_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // R5
    rvalid_q |=> !rvalid_q)
    else $error("read valid longer than one cycle");
  standby_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R11
    (standby_req && !reset_req && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("request taken in standby");
  read_len_a: assert property (@(posedge clk) disable iff (!rstn) // R12
    $fell(oe_n_q) |-> !oe_n_q [*3])
    else $error("read strobes shorter than access time");
  word_drive_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    (byte_n_q && !we_n_q) |-> dq_oe_q == 16'hFFFF)
    else $error("word write not driving all pins");
  byte_drive_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    (!byte_n_q && !we_n_q) |-> dq_oe_q == 16'h80FF)
    else $error("byte write drive pattern wrong");
  we_rise_a: assert property (@(posedge clk) disable iff (!rstn) // R21
    $rose(we_n_q) |-> !ce_n_q)
    else $error("chip select rose with write strobe");
endmodule

/* sim/flash_model.sv */
// behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module flash_model (
  input wire logic clk, // drives only the float pattern
  input wire logic [17:0] addr, // address pins
  input wire logic ce_n, // chip select
  input wire logic oe_n, // output enable
  input wire logic we_n, // write strobe
  input wire logic rst_n, // hardware reset
  input wire logic byte_n, // width select
  input wire logic [15:0] dq_out, // host data
  input wire logic [15:0] dq_oe, // host data enables
  output logic [15:0] dq_in, // resolved data bus
  output logic ready_busy_out // low while busy
);
  logic [7:0] mem [256];
  logic [15:0] rd, mdrv;
  logic [7:0] wa;
  logic tog = 1'b0;
  initial begin
    ready_busy_out = 1'b1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  // undriven lines flip every cycle so stale data never passes
  always @(posedge clk) tog <= ~tog;
  assign wa = {addr[6:0], byte_n ? 1'b0 : (dq_oe[15] ? dq_out[15] : tog)};
  assign rd = byte_n ? {mem[wa | 8'h01], mem[wa]} : {8'h00, mem[wa]};
  assign mdrv = (!ce_n && !oe_n && rst_n) ? (byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      dq_in[i] = dq_oe[i] ? dq_out[i] : (mdrv[i] ? rd[i] : tog);
    end
  end
  // data taken on the earlier rising strobe
  always @(posedge we_n or posedge ce_n) begin
    if (rst_n && oe_n && !(we_n && ce_n)) begin
      mem[wa] = dq_in[7:0];
      if (byte_n) mem[wa | 8'h01] = dq_in[15:8];
      ready_busy_out <= 1'b0;
      ready_busy_out <= #300 1'b1;
    end
  end
  always @(negedge rst_n) ready_busy_out <= #100 1'b1;
endmodule

/* sim/tb_flash_host.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_flash_host;
  logic clk = 0, rstn = 0, word_mode = 1, top_boot = 1, req_valid = 0, req_write = 0;
  logic req_lsb = 0, reset_req = 0, standby_req = 0;
  logic [18:0] req_addr = '0;
  logic [15:0] req_wdata = '0, rdata_q, dq_out_q, dq_oe_q, dq_in;
  logic busy_q, rvalid_q, dev_busy_q, ce_n_q, oe_n_q, we_n_q, rst_n_q, byte_n_q, ready_busy_out;
  logic [3:0] sector_q;
  logic [17:0] addr_q;
  logic [15:0] exp_q [$];
  logic [15:0] wd [8];
  logic [31:0] seed = 32'h0000_0062;
  logic [18:0] sa [12] = '{19'h0_0000, 19'h3_7fff, 19'h3_8000, 19'h3_c000, 19'h3_d000,
    19'h3_e000, 19'h0_1fff, 19'h0_2000, 19'h0_3000, 19'h0_4000, 19'h0_8000, 19'h3_8000};
  int se [12] = '{0, 6, 7, 8, 9, 10, 0, 1, 2, 3, 4, 10};
  int num_errors = 0, tests_run = 0, cycles = 0;
  always #20 clk = ~clk;
  flash_host #(.RESET_CYCLES(2)) i_dut (.clk(clk), .rstn(rstn), .word_mode(word_mode),
    .top_boot(top_boot), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_lsb(req_lsb), .req_wdata(req_wdata), .reset_req(reset_req),
    .standby_req(standby_req), .busy_q(busy_q), .rvalid_q(rvalid_q), .rdata_q(rdata_q),
    .sector_q(sector_q), .dev_busy_q(dev_busy_q), .addr_q(addr_q), .ce_n_q(ce_n_q),
    .oe_n_q(oe_n_q), .we_n_q(we_n_q), .rst_n_q(rst_n_q), .byte_n_q(byte_n_q),
    .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
  flash_model i_flash (.clk(clk), .addr(addr_q), .ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q),
    .rst_n(rst_n_q), .byte_n(byte_n_q), .dq_out(dq_out_q), .dq_oe(dq_oe_q), .dq_in(dq_in),
    .ready_busy_out(ready_busy_out));
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("wrong value %s exp %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a refused read notes nothing, so any answer to it shows as spurious
  task automatic access(logic wr, logic [18:0] a, logic lsb, logic [15:0] d, logic [15:0] e);
    @(negedge clk);
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_lsb = lsb;
    req_wdata = d;
    if (!wr && !standby_req) exp_q.push_back(e);
    @(negedge clk);
    req_valid = 0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 20 && busy_q !== 1'b0; i++) @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (rvalid_q === 1'b1) begin
      if (exp_q.size() == 0) check("spurious rvalid", 16'h0001, 16'h0000);
      else check("rdata", rdata_q, exp_q.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 8; i++) begin
      wd[i] = xs();
      access(1, 19'(i * 5), 0, wd[i], 16'h0000);
    end
    for (int i = 0; i < 8; i++) access(0, 19'(i * 5), 0, 16'h0000, wd[i]);
    $display("test word done");
    // reset lands while the device is still busy programming
    access(1, 19'h0_0028, 0, 16'hbeef, 16'h0000);
    check("dev busy", {15'h0, dev_busy_q}, 16'h0001);
    @(negedge clk);
    reset_req = 1;
    @(negedge clk);
    reset_req = 0;
    for (int i = 0; i < 10 && rst_n_q !== 1'b0; i++) @(negedge clk);
    check("rst pin", {15'h0, rst_n_q}, 16'h0000);
    check("dq float", dq_oe_q, 16'h0000);
    repeat (20) @(negedge clk);
    check("dev ready", {15'h0, dev_busy_q}, 16'h0000);
    access(0, 19'h0_0000, 0, 16'h0000, wd[0]);
    access(1, 19'h0_0028, 0, 16'hbeef, 16'h0000);
    access(0, 19'h0_0028, 0, 16'h0000, 16'hbeef);
    $display("test reset done");
    word_mode = 0;
    for (int i = 0; i < 2; i++) access(1, 19'h0_0032, i[0], 16'h00a0 + 16'(i), 16'h0000);
    check("byte pin", {15'h0, byte_n_q}, 16'h0000);
    for (int i = 0; i < 2; i++) access(0, 19'h0_0032, i[0], 16'h0000, 16'h00a0 + 16'(i));
    word_mode = 1;
    $display("test byte done");
    standby_req = 1;
    repeat (2) @(negedge clk);
    check("standby ce", {15'h0, ce_n_q}, 16'h0001);
    access(0, 19'h0_0005, 0, 16'h0000, 16'h0000);
    standby_req = 0;
    access(0, 19'h0_0005, 0, 16'h0000, wd[1]);
    $display("test standby done");
    for (int i = 0; i < 12; i++) begin
      top_boot = (i < 6);
      req_addr = sa[i];
      repeat (3) @(negedge clk);
      check("sector", {12'h000, sector_q}, 16'(se[i]));
    end
    $display("test sector done");
    repeat (8) @(negedge clk);
    test_done();
  end
endmodule
